// ### core/aer_router.sv
// Converter clock gate, pin enables, interrupt mapping and event routing
//
// Operation
// [R1] Bit 0 of peripheral management register gates converter clock; resets to 1.
// [R2] Converter kernel runs from the fixed 48 MHz peripheral clock.
// [R3] Software selects system page 1, map 0, before touching the register.
// [R4] Port 2 pin n becomes analog channel n when its enable is 1.
// [R5] Source completion sets its flag; enabled source raises request line 0.
// [R6] Channel event sets channel flag; global channel enable raises line 0.
// [R7] Result event sets its flag; that register's enable raises line 0.
// [R8] Out-of-range event sets flag; global out-of-range enable raises line 1.
// [R9] Lines 0 and 1 share one node, one enable, vector 33h, two pendings.
// [R10] Combined channel event drives both timer run inputs at select 11.
// [R11] Channel event 0 drives trap input at trap select 11.
// [R12] Channel events 1 and 2 connect to nothing.
// [R13] Boundary event n drives capture n and Hall input n at select 11.
// [R14] Out-of-range 0 drives timer external input at 100, timer12 run at 001/00.
// [R15] Out-of-range 1 drives timer external input at select 101.
// [R16] Out-of-range 2 drives both timer runs at system 100, unit 00.
// [R17] Every routed output is a one-cycle pulse on the peripheral clock.
// [R18] While clock-off is requested, flags hold and all routed outputs stay low.
`timescale 1ns/100ps
`default_nettype none
module aer_router
    import aer_pkg::*;
#(
    parameter int CLK_MHZ = PCLK_MHZ
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_n_i,
    // Special function register port
    input  wire logic [7:0]            sfr_addr_i,
    input  wire logic                  sfr_wr_i,
    input  wire logic                  sfr_rd_i,
    input  wire logic [7:0]            sfr_wdata_i,
    input  wire logic [3:0]            system_page_select_i,
    input  wire logic                  register_map_select_i,
    output logic      [7:0]            sfr_rdata_o,
    output logic                       sfr_hit_o,
    // Pin enables
    input  wire logic [7:0]            port_two_digital_input_enable_i,
    output logic      [7:0]            analog_channel_enable_o,
    // Kernel side
    input  wire aer_pkg::aer_events_t  events_i,
    input  wire aer_pkg::aer_enables_t enables_i,
    input  wire logic [1:0]            flag_clear_i,
    output logic                       converter_clock_enable_o,
    output logic      [1:0]            event_flag_o,
    output logic      [7:0]            channel_event_flag_o,
    output logic      [3:0]            result_event_flag_o,
    output logic      [7:0]            out_of_range_flag_o,
    // Interrupt node
    input  wire logic                  converter_node_enable_i,
    input  wire logic [1:0]            pending_clear_i,
    output logic                       request_zero_pending_o,
    output logic                       request_one_pending_o,
    output logic                       node_request_o,
    output logic      [7:0]            node_vector_o,
    // Routed events
    input  wire aer_pkg::aer_selects_t selects_i,
    output aer_pkg::aer_routed_t       routed_o
);
    import aer_pkg::*;

    // Elaboration guard: the kernel only runs from the fixed peripheral rate
    if (CLK_MHZ != PCLK_MHZ) begin : g_bad_clock
        $error("aer_router: peripheral clock must be the fixed rate");
    end

    logic [7:0]  pcg;
    logic [7:0]  next_pcg;
    logic        sel_hit;
    logic        clk_off;
    logic [1:0]  ev_flag, next_ev_flag;
    logic [7:0]  ch_flag, next_ch_flag;
    logic [3:0]  res_flag, next_res_flag;
    logic [7:0]  orc_flag, next_orc_flag;
    logic        sr0, sr1;
    logic [1:0]  pend, next_pend;
    aer_routed_t next_routed;

    // Register is visible only on page 1 of the standard map
    assign sel_hit = (sfr_addr_i == PCG_ADDR) && (system_page_select_i == PCG_PAGE)
                     && (register_map_select_i == PCG_MAP_SEL); // R3
    assign clk_off = pcg[CLK_OFF_BIT];
    assign sfr_hit_o = sel_hit && (sfr_wr_i || sfr_rd_i);
    assign sfr_rdata_o = (sel_hit && sfr_rd_i) ? pcg : 8'h00;

    // Register write path
    always_comb begin
        next_pcg = pcg;
        if (sel_hit && sfr_wr_i) begin
            next_pcg = sfr_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pcg <= PCG_RESET; // R1
        end else begin
            pcg <= next_pcg;
        end
    end

    // Kernel clock gate and analog pin enables
    assign converter_clock_enable_o = !clk_off; // R1 R2
    assign analog_channel_enable_o  = port_two_digital_input_enable_i; // R4

    // Event flags: set wins over clear, frozen while clock is off
    always_comb begin
        next_ev_flag  = ev_flag;
        next_ch_flag  = ch_flag;
        next_res_flag = res_flag;
        next_orc_flag = orc_flag;
        if (!clk_off) begin // R18
            if (flag_clear_i[0]) begin
                next_ev_flag  = '0;
                next_res_flag = '0;
                next_ch_flag  = '0;
            end
            if (flag_clear_i[1]) begin
                next_orc_flag = '0;
            end
            next_ev_flag  = next_ev_flag | events_i.source; // R5
            next_ch_flag  = next_ch_flag | events_i.channel; // R6
            next_res_flag = next_res_flag | events_i.result; // R7
            next_orc_flag = next_orc_flag | events_i.out_of_range; // R8
        end
    end

    // Service request lines from enabled events
    always_comb begin
        sr0 = 1'b0;
        sr1 = 1'b0;
        if (!clk_off) begin // R18
            sr0 = |(events_i.source & enables_i.source_event_irq_enable) // R5
                | (|events_i.channel & enables_i.channel_event_irq_enable) // R6
                | |(events_i.result & enables_i.result_irq_enable); // R7
            sr1 = |events_i.out_of_range & enables_i.out_of_range_irq_enable; // R8
        end
    end

    // Two pending flags on one node; set wins over clear
    always_comb begin
        next_pend = (pend & ~pending_clear_i) | {sr1, sr0}; // R9
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ev_flag  <= '0;
            ch_flag  <= '0;
            res_flag <= '0;
            orc_flag <= '0;
            pend     <= '0;
        end else begin
            ev_flag  <= next_ev_flag;
            ch_flag  <= next_ch_flag;
            res_flag <= next_res_flag;
            orc_flag <= next_orc_flag;
            pend     <= next_pend;
        end
    end

    assign event_flag_o           = ev_flag;
    assign channel_event_flag_o   = ch_flag;
    assign result_event_flag_o    = res_flag;
    assign out_of_range_flag_o    = orc_flag;
    assign request_zero_pending_o = pend[0];
    assign request_one_pending_o  = pend[1];
    assign node_request_o = converter_node_enable_i && (|pend); // R9
    assign node_vector_o  = NODE_VECTOR; // R9

    // Event routing; channel events 1 and 2 are deliberately left unused
    always_comb begin
        next_routed = '0;
        if (!clk_off) begin // R18
            next_routed.timer12_hardware_run =
                (events_i.combined && selects_i.timer12_run_input_select == SEL_CONV) // R10
                || (events_i.out_of_range[0] // R14
                    && selects_i.system_timer12_run_select == SYS_RUN_ORC0
                    && selects_i.timer12_run_input_select == SEL_PIN)
                || (events_i.out_of_range[2] // R16
                    && selects_i.system_timer12_run_select == SYS_RUN_ORC2
                    && selects_i.timer12_run_input_select == SEL_PIN);
            next_routed.timer13_hardware_run =
                (events_i.combined && selects_i.timer13_run_input_select == SEL_CONV) // R10
                || (events_i.out_of_range[2] // R16
                    && selects_i.system_timer13_run_select == SYS_RUN_ORC2
                    && selects_i.timer13_run_input_select == SEL_PIN);
            next_routed.trap_input = events_i.chan_ev[0]
                && selects_i.trap_input_select == SEL_CONV; // R11 R12
            next_routed.timer_external_input =
                (events_i.out_of_range[0]
                 && selects_i.timer_external_input_select == EXT_ORC0) // R14
                || (events_i.out_of_range[1]
                 && selects_i.timer_external_input_select == EXT_ORC1); // R15
            for (int n = 0; n < 3; n++) begin
                next_routed.capture_input[n] = events_i.boundary[n]
                    && selects_i.capture_select[2*n +: 2] == SEL_CONV; // R13
                next_routed.hall_position_input[n] = events_i.boundary[n]
                    && selects_i.hall_select[2*n +: 2] == SEL_CONV; // R13
            end
        end
    end

    // Registered routing outputs, one cycle per kernel event pulse
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            routed_o <= '0;
        end else begin
            routed_o <= next_routed; // R17
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    reset_gate_a: assert property (!$past(rst_n_i) |-> clk_off) // R1
        else $error("clock-off bit not set after reset");
    clock_gate_a: assert property (sfr_wr_i && sel_hit |=> // R1
        converter_clock_enable_o == !$past(sfr_wdata_i[CLK_OFF_BIT]))
        else $error("kernel clock enable does not follow the written gate bit");
    page_write_a: assert property (sfr_wr_i && sfr_addr_i == PCG_ADDR // R3
        && system_page_select_i != PCG_PAGE |=> $stable(pcg))
        else $error("register written from wrong page");
    src_request_a: assert property (!clk_off && |(events_i.source // R5
        & enables_i.source_event_irq_enable) |=> pend[0])
        else $error("source event did not raise line 0 pending");
    res_flag_a: assert property (!clk_off && events_i.result[0] |=> res_flag[0]) // R7
        else $error("result event flag lost");
    orc_request_a: assert property (!clk_off && |events_i.out_of_range // R8
        && enables_i.out_of_range_irq_enable |=> pend[1])
        else $error("out-of-range event did not raise line 1 pending");
    node_req_a: assert property ((sr0 || sr1) && converter_node_enable_i |=> // R9
        node_request_o || !converter_node_enable_i)
        else $error("node request missing after an enabled service request");
    trap_route_a: assert property (!clk_off && events_i.chan_ev[0] // R11
        && selects_i.trap_input_select == SEL_CONV |=> routed_o.trap_input)
        else $error("trap input not routed");
    ext_route_a: assert property (!clk_off && events_i.out_of_range[1] // R15
        && selects_i.timer_external_input_select == EXT_ORC1
        |=> routed_o.timer_external_input)
        else $error("timer external input not routed");
    pulse_once_a: assert property (routed_o.trap_input |-> $past(events_i.chan_ev[0])) // R17
        else $error("routed pulse without source event");
    frozen_a: assert property (clk_off |=> $stable(orc_flag) && routed_o == '0) // R18
        else $error("activity while clock is off");

    // Line 0 sources besides the request sources, the channel flag, and the line 1 out-of-range flag
    chan_request_a: assert property (!clk_off && |events_i.channel // R6
        && enables_i.channel_event_irq_enable |=> pend[0])
        else $error("channel event did not raise line 0 pending");
    chan_flag_a: assert property (!clk_off && events_i.channel[7] |=> ch_flag[7]) // R6
        else $error("channel event flag lost");
    res_request_a: assert property (!clk_off && |(events_i.result // R7
        & enables_i.result_irq_enable) |=> pend[0])
        else $error("result event did not raise line 0 pending");
    orc_flag_a: assert property (!clk_off && events_i.out_of_range[0] |=> orc_flag[0]) // R8
        else $error("out-of-range flag lost");

    // Pending bits stay until software clears them
    pend_hold_a: assert property (pend[1] && !pending_clear_i[1] |=> pend[1]) // R9
        else $error("line 1 pending dropped without a clear");
    zero_hold_a: assert property (pend[0] && !pending_clear_i[0] |=> pend[0]) // R9
        else $error("line 0 pending dropped without a clear");

    // Routing of channel and boundary events
    run_route_a: assert property (!clk_off && events_i.combined // R10
        && selects_i.timer13_run_input_select == SEL_CONV
        |=> routed_o.timer13_hardware_run)
        else $error("combined channel event not routed to timer run");
    trap_quiet_a: assert property (!events_i.chan_ev[0] |=> !routed_o.trap_input) // R12
        else $error("trap input fired without channel event 0");
    capture_route_a: assert property (!clk_off && events_i.boundary[0] // R13
        && selects_i.capture_select[1:0] == SEL_CONV |=> routed_o.capture_input[0])
        else $error("boundary event not routed to capture input");
    hall_route_a: assert property (!clk_off && events_i.boundary[2] // R13
        && selects_i.hall_select[5:4] == SEL_CONV |=> routed_o.hall_position_input[2])
        else $error("boundary event not routed to position input");

    // Routing of out-of-range events
    ext_zero_a: assert property (!clk_off && events_i.out_of_range[0] // R14
        && selects_i.timer_external_input_select == EXT_ORC0
        |=> routed_o.timer_external_input)
        else $error("out-of-range event 0 not routed to external input");
    run_zero_a: assert property (!clk_off && events_i.out_of_range[0] // R14
        && selects_i.system_timer12_run_select == SYS_RUN_ORC0
        && selects_i.timer12_run_input_select == SEL_PIN
        |=> routed_o.timer12_hardware_run)
        else $error("out-of-range event 0 not routed to timer run");
    orc_run_a: assert property (!clk_off && events_i.out_of_range[2] // R16
        && selects_i.system_timer13_run_select == SYS_RUN_ORC2
        && selects_i.timer13_run_input_select == SEL_PIN
        |=> routed_o.timer13_hardware_run)
        else $error("out-of-range event 2 not routed to timer run");

    cov_sr0_c: cover property (pend[0] && node_request_o);
    cov_sr1_c: cover property (pend[1]);
    cov_run_c: cover property (routed_o.timer12_hardware_run);
    cov_wake_c: cover property ($fell(clk_off));
    cov_route_c: cover property (routed_o.capture_input != 3'h0);
endmodule : aer_router
`default_nettype wire

// ### core/aer_pkg.sv
// Package of constants and types for the converter event routing block
`default_nettype none
package aer_pkg;
    // Peripheral management register
    localparam logic [7:0] PCG_ADDR      = 8'hef;
    localparam logic [7:0] PCG_RESET     = 8'hff;
    localparam int         CLK_OFF_BIT   = 0;
    localparam logic [3:0] PCG_PAGE      = 4'h1;
    localparam logic       PCG_MAP_SEL   = 1'b0;
    localparam logic [7:0] NODE_VECTOR   = 8'h33;
    // Peripheral clock rate, fixed
    localparam int         PCLK_MHZ      = 48;
    // Select codes
    localparam logic [1:0] SEL_CONV      = 2'h3;
    localparam logic [1:0] SEL_PIN       = 2'h0;
    localparam logic [2:0] EXT_ORC0      = 3'h4;
    localparam logic [2:0] EXT_ORC1      = 3'h5;
    localparam logic [2:0] SYS_RUN_ORC0  = 3'h1;
    localparam logic [2:0] SYS_RUN_ORC2  = 3'h4;

    // Raw events from the kernel
    typedef struct packed {
        logic [1:0] source;
        logic [7:0] channel;
        logic [3:0] result;
        logic [7:0] out_of_range;
        logic       combined;
        logic [2:0] chan_ev;
        logic [2:0] boundary;
    } aer_events_t;

    // Select fields held in the capture/compare unit and system control
    typedef struct packed {
        logic [1:0] timer12_run_input_select;
        logic [1:0] timer13_run_input_select;
        logic [1:0] trap_input_select;
        logic [5:0] capture_select;
        logic [5:0] hall_select;
        logic [2:0] timer_external_input_select;
        logic [2:0] system_timer12_run_select;
        logic [2:0] system_timer13_run_select;
    } aer_selects_t;

    // Routed event pulses
    typedef struct packed {
        logic       timer12_hardware_run;
        logic       timer13_hardware_run;
        logic       trap_input;
        logic [2:0] capture_input;
        logic [2:0] hall_position_input;
        logic       timer_external_input;
    } aer_routed_t;

    // Interrupt enables
    typedef struct packed {
        logic [1:0] source_event_irq_enable;
        logic       channel_event_irq_enable;
        logic [3:0] result_irq_enable;
        logic       out_of_range_irq_enable;
    } aer_enables_t;
endpackage : aer_pkg
`default_nettype wire

// ### verif/aer_far_model.sv
// Far-side model: capture/compare unit and timer inputs fed by routed events
`timescale 1ns/100ps
`default_nettype none
module aer_far_model
    import aer_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 clr_i,
    input  wire aer_pkg::aer_routed_t routed_i,
    output logic      [9:0]           seen_o,
    output logic      [7:0]           cyc_o
);
    // Collect which inputs fired and in how many cycles anything fired
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_o <= '0;
            cyc_o  <= '0;
        end else if (clr_i) begin
            seen_o <= '0;
            cyc_o  <= '0;
        end else begin
            seen_o <= seen_o | routed_i;
            cyc_o  <= cyc_o + 8'(|routed_i);
        end
    end
endmodule : aer_far_model
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the converter event routing block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value at %0t: got %h exp %h", $time, (g), (e)); end end
module testbench;
    import aer_pkg::*;
    logic         sys_clk_i = 0, rst_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0;
    logic         reg_map = 0, node_en = 0, clr = 0, hit, clk_en, pend0, pend1, nreq;
    logic   [7:0] addr = 0, wdata = 0, p2en = 0, rdata, vec, chf, orf, ach, cyc;
    logic   [3:0] page = 0, rsf;
    logic   [1:0] fclr = 0, pclr = 0, evf;
    logic   [9:0] seen;
    aer_events_t  ev = '0;
    aer_enables_t en = '0;
    aer_selects_t sel = '0;
    aer_routed_t  routed;
    int           err_total = 0, n_tests = 0, cycles = 0;

    // Design and far-side model
    aer_router uut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(wdata), .system_page_select_i(page),
        .register_map_select_i(reg_map), .sfr_rdata_o(rdata), .sfr_hit_o(hit),
        .port_two_digital_input_enable_i(p2en), .analog_channel_enable_o(ach),
        .events_i(ev), .enables_i(en), .flag_clear_i(fclr), .converter_clock_enable_o(clk_en),
        .event_flag_o(evf), .channel_event_flag_o(chf), .result_event_flag_o(rsf),
        .out_of_range_flag_o(orf), .converter_node_enable_i(node_en), .pending_clear_i(pclr),
        .request_zero_pending_o(pend0), .request_one_pending_o(pend1), .node_request_o(nreq),
        .node_vector_o(vec), .selects_i(sel), .routed_o(routed)
    );
    aer_far_model far (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clr_i(clr),
        .routed_i(routed), .seen_o(seen), .cyc_o(cyc));

    // Clock and hang guard
    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            finish_test;
        end
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // Register write on page pg, map 0
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] pg);
        @(negedge sys_clk_i);
        addr     = a;
        wdata    = d;
        page     = pg;
        sfr_wr_i = 1'b1;
        @(negedge sys_clk_i);
        sfr_wr_i = 1'b0;
    endtask : wr

    // Register read, data and hit judged while the strobe stands
    task automatic rd(input logic [7:0] a, input logic [3:0] pg, input logic mp,
                      input logic [7:0] xd, input logic xh);
        @(negedge sys_clk_i);
        addr     = a;
        page     = pg;
        reg_map  = mp;
        sfr_rd_i = 1'b1;
        #1;
        `CHK(rdata, xd)
        `CHK(hit, xh)
        @(negedge sys_clk_i);
        sfr_rd_i = 1'b0;
        reg_map  = 1'b0;
    endtask : rd

    task automatic pulse(input aer_events_t e);
        @(negedge sys_clk_i);
        ev = e;
        @(negedge sys_clk_i);
        ev = '0;
    endtask : pulse

    task automatic clrall;
        @(negedge sys_clk_i);
        fclr = 2'h3;
        pclr = 2'h3;
        @(negedge sys_clk_i);
        fclr = 2'h0;
        pclr = 2'h0;
    endtask : clrall

    task automatic t_reg;
        rd(PCG_ADDR, 4'h1, 1'b0, 8'hff, 1'b1);
        `CHK(clk_en, 1'b0)
        rd(PCG_ADDR, 4'h2, 1'b0, 8'h00, 1'b0);
        rd(PCG_ADDR, 4'h1, 1'b1, 8'h00, 1'b0);
        rd(8'hee, 4'h1, 1'b0, 8'h00, 1'b0);
        wr(PCG_ADDR, 8'h00, 4'h0);
        rd(PCG_ADDR, 4'h1, 1'b0, 8'hff, 1'b1);
        $display("test reg done");
    endtask : t_reg

    // Everything enabled and all but the out-of-range routes selected, yet the gated converter stays silent
    task automatic t_gate;
        en      = '1;
        node_en = 1'b1;
        sel     = '1;
        clr     = 1'b1;
        pulse('1);
        clr     = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        `CHK(clk_en, 1'b0)
        `CHK({evf, chf, rsf, orf, pend1, pend0, nreq}, 25'h0)
        `CHK(seen, 10'h0)
        $display("test gate done");
    endtask : t_gate

    task automatic t_run;
        wr(PCG_ADDR, 8'hfe, 4'h1);
        `CHK(clk_en, 1'b1)
        rd(PCG_ADDR, 4'h1, 1'b0, 8'hfe, 1'b1);
        p2en = 8'ha5;
        #1;
        `CHK(ach, 8'ha5)
        `CHK(vec, 8'h33)
        $display("test run done");
    endtask : t_run

    // One event with enables n; p is the expected {line 1, line 0} pending pair
    task automatic irq(input aer_events_t e, input aer_enables_t n, input logic [1:0] p);
        en      = n;
        node_en = 1'b1;
        pulse(e);
        @(negedge sys_clk_i);
        `CHK({evf, chf, rsf, orf}, {e.source, e.channel, e.result, e.out_of_range})
        `CHK({pend1, pend0}, p)
        `CHK(nreq, |p)
        node_en = 1'b0;
        #1;
        `CHK(nreq, 1'b0)
        clrall;
    endtask : irq

    task automatic t_irq;
        irq(29'h1000_0000, 8'h80, 2'b01);
        irq(29'h0800_0000, 8'hbf, 2'b00);
        irq(29'h0040_0000, 8'h20, 2'b01);
        irq(29'h0002_0000, 8'h08, 2'b01);
        irq(29'h0002_0000, 8'hf7, 2'b00);
        irq(29'h0000_1000, 8'h01, 2'b10);
        irq(29'h0000_1000, 8'hfe, 2'b00);
        $display("test irq done");
    endtask : t_irq

    // One event under selects s; m is the expected set of far-side inputs hit
    task automatic route(input aer_events_t e, input aer_selects_t s, input logic [9:0] m);
        sel = s;
        en  = '0;
        clr = 1'b1;
        pulse(e);
        clr = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        `CHK(seen, m)
        `CHK(cyc, 8'(m != 10'h0))
    endtask : route

    task automatic t_route;
        route(29'h40, 27'h7aaaa00, 10'h300);
        route(29'h40, 27'h2aaaa00, 10'h000);
        route(29'h8, 27'h2eaaa00, 10'h080);
        route(29'h30, 27'h7ffffff, 10'h000);
        route(29'h2, 27'h2bffe00, 10'h024);
        route(29'h5, 27'h2bffe00, 10'h05a);
        route(29'h80, 27'h0aaab08, 10'h201);
        route(29'h100, 27'h2aaab40, 10'h001);
        route(29'h100, 27'h2aaab00, 10'h000);
        route(29'h200, 27'h02aaa24, 10'h300);
        $display("test route done");
    endtask : t_route

    // Main sequence
    initial begin
        repeat (20) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        t_reg;
        t_gate;
        t_run;
        t_irq;
        t_route;
        clrall;
        wr(PCG_ADDR, 8'h01, 4'h1);
        t_gate;
        finish_test;
    end
endmodule : testbench
`default_nettype wire
